/* File: src/redundant_port.v */
// Redundancy layer between one upper frame stream and two network ports.
// Assumes byte streams with valid, last and source/sequence sidebands
// delivered per frame; network ports never stall a byte.
// Summary of operation
// - In parallel mode every outgoing frame is sent on both ports.
// - In parallel mode the first copy received is passed up, the later one dropped.
// - In parallel mode arrival order and reception on both ports are checked.
// - The upper side sees one network with no switchover in parallel mode.
// - In parallel or ring mode a supervision frame goes out each life-check period.
// - The mode is one of failover, spanning tree, parallel or ring.
// - In failover mode a selectable main port is active until switch-over.
// - Switch-over follows a failover time clamped to no less than 2 s.
// - Spanning tree settings default and clamp to their documented ranges.
// - In spanning tree mode no frame that starts during recalculation is forwarded.
// - In failover mode only one port is active, the spare only on link loss.
`timescale 1ns/10ps
`include "redundant_port_map.vh"

module redundant_port #(
   parameter LIFE_CHECK_MS = `LIFE_CHECK_DEF_MS,
   parameter CYCLES_MS     = `CYCLES_PER_MS
) (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire [1:0]  mode,
   input  wire        main_port_b,
   input  wire [15:0] failover_ms,
   input  wire [15:0] life_check_ms,
   input  wire [47:0] sup_dest_addr,
   input  wire [5:0]  max_age_set,
   input  wire [5:0]  hello_set,
   input  wire [5:0]  fwd_delay_set,
   input  wire [15:0] priority_set,
   input  wire        topology_recalc,
   input  wire        link_a,
   input  wire        link_b,
   input  wire [7:0]  up_tx_data,
   input  wire        up_tx_valid,
   input  wire        up_tx_last,
   output wire        up_tx_ready,
   output reg  [7:0]  up_rx_data,
   output reg         up_rx_valid,
   output reg         up_rx_last,
   output reg  [7:0]  a_tx_data,
   output reg         a_tx_valid,
   output reg         a_tx_last,
   output reg  [7:0]  b_tx_data,
   output reg         b_tx_valid,
   output reg         b_tx_last,
   input  wire [7:0]  a_rx_data,
   input  wire        a_rx_valid,
   input  wire        a_rx_last,
   input  wire [47:0] a_rx_src,
   input  wire [15:0] a_rx_seq,
   input  wire [7:0]  b_rx_data,
   input  wire        b_rx_valid,
   input  wire        b_rx_last,
   input  wire [47:0] b_rx_src,
   input  wire [15:0] b_rx_seq,
   output reg         active_b,
   output reg         dup_dropped,
   output reg         seq_error,
   output reg         missing_copy,
   output reg  [5:0]  max_age,
   output reg  [5:0]  hello_time,
   output reg  [5:0]  fwd_delay,
   output reg  [15:0] bridge_priority
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function [5:0] clamp6;
      input [5:0] v;
      input [5:0] lo;
      input [5:0] hi;
      begin
         clamp6 = (v < lo) ? lo : ((v > hi) ? hi : v);
      end
   endfunction

   wire tick;
   ms_tick #(.CYCLES(CYCLES_MS)) u_tick (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tick     (tick)
   );

   // Link pins are asynchronous and pass two flip-flops.
   reg [1:0] link_a_s;
   reg [1:0] link_b_s;
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_a_s <= 2'h0;
         link_b_s <= 2'h0;
      end else begin
         link_a_s <= {link_a_s[0], link_a};
         link_b_s <= {link_b_s[0], link_b};
      end
   end

   wire parallel = (mode == `MODE_PRP) || (mode == `MODE_HSR);
   wire stp_hold = (mode == `MODE_RSTP) && topology_recalc;

   // ****************************************************************
   // Spanning tree settings
   // ****************************************************************
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         max_age         <= `MAX_AGE_DEF;
         hello_time      <= `HELLO_DEF;
         fwd_delay       <= `FWD_DELAY_DEF;
         bridge_priority <= `PRIORITY_DEF;
      end else begin
         max_age    <= clamp6(max_age_set, `MAX_AGE_MIN, `MAX_AGE_MAX);
         hello_time <= clamp6(hello_set, `HELLO_MIN, `HELLO_MAX);
         fwd_delay  <= clamp6(fwd_delay_set, `FWD_DELAY_MIN,
                              `FWD_DELAY_MAX);
         bridge_priority <= (priority_set > `PRIORITY_MAX) ?
                            `PRIORITY_MAX : {priority_set[15:12], 12'h000};
      end
   end

   // ****************************************************************
   // Failover selection
   // ****************************************************************
   wire [15:0] fo_limit = (failover_ms < `FAILOVER_MIN_MS) ?
                          `FAILOVER_MIN_MS : failover_ms;
   reg  [15:0] fo_count;
   wire        main_up = main_port_b ? link_b_s[1] : link_a_s[1];
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fo_count <= 16'h0;
         active_b <= 1'b0;
      end else if (mode != `MODE_FAILOVER || main_up) begin
         fo_count <= 16'h0;
         active_b <= main_port_b;
      end else if (tick) begin
         if (fo_count >= fo_limit - 16'h1)
            active_b <= ~main_port_b;
         else
            fo_count <= fo_count + 16'h1;
      end
   end

   // ****************************************************************
   // Supervision timer and transmit path
   // ****************************************************************
   reg [15:0] life_count;
   reg        sup_pending;
   reg        sup_busy;
   reg [4:0]  sup_idx;
   reg        in_frame;
   wire [15:0] life_lim = (life_check_ms == 16'h0) ?
                          LIFE_CHECK_MS[15:0] : life_check_ms;

   // Supervision frames wait for the gap between upper frames.
   assign up_tx_ready = !sup_busy && !stp_hold;

   wire [7:0] sup_byte = (sup_idx < 5'h6) ?
                         sup_dest_addr[8'd47 - {sup_idx, 3'h0} -: 8] :
                         8'h88;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         life_count  <= 16'h0;
         sup_pending <= 1'b0;
         sup_busy    <= 1'b0;
         sup_idx     <= 5'h0;
         in_frame    <= 1'b0;
         a_tx_data   <= 8'h00;
         a_tx_valid  <= 1'b0;
         a_tx_last   <= 1'b0;
         b_tx_data   <= 8'h00;
         b_tx_valid  <= 1'b0;
         b_tx_last   <= 1'b0;
      end else begin
         a_tx_valid <= 1'b0;
         b_tx_valid <= 1'b0;
         a_tx_last  <= 1'b0;
         b_tx_last  <= 1'b0;
         if (parallel && tick) begin
            if (life_count >= life_lim - 16'h1) begin
               life_count  <= 16'h0;
               sup_pending <= 1'b1;
            end else
               life_count <= life_count + 16'h1;
         end
         if (sup_busy) begin
            a_tx_data  <= sup_byte;
            b_tx_data  <= sup_byte;
            a_tx_valid <= 1'b1;
            b_tx_valid <= 1'b1;
            a_tx_last  <= (sup_idx == `SUP_LEN - 5'h1);
            b_tx_last  <= (sup_idx == `SUP_LEN - 5'h1);
            sup_idx    <= sup_idx + 5'h1;
            if (sup_idx == `SUP_LEN - 5'h1)
               sup_busy <= 1'b0;
         end else if (up_tx_valid && up_tx_ready) begin
            in_frame  <= !up_tx_last;
            a_tx_data <= up_tx_data;
            b_tx_data <= up_tx_data;
            a_tx_last <= up_tx_last;
            b_tx_last <= up_tx_last;
            if (parallel) begin
               a_tx_valid <= 1'b1;
               b_tx_valid <= 1'b1;
            end else if (mode == `MODE_FAILOVER) begin
               a_tx_valid <= !active_b;
               b_tx_valid <= active_b;
            end else
               a_tx_valid <= 1'b1;
         end else if (sup_pending && !in_frame && parallel) begin
            sup_pending <= 1'b0;
            sup_busy    <= 1'b1;
            sup_idx     <= 5'h0;
         end
      end
   end

   // ****************************************************************
   // Receive path with duplicate discard
   // ****************************************************************
   reg [47:0] dup_src [0:`DUP_ENTRIES-1];
   reg [15:0] dup_seq [0:`DUP_ENTRIES-1];
   reg        dup_val [0:`DUP_ENTRIES-1];
   reg [`DUP_IDX_W-1:0] dup_wr;
   reg [15:0] last_seq;
   reg        a_drop;
   reg        b_drop;
   reg        a_in;
   reg        b_in;
   integer    i;
   integer    j;

   // Port A owns the upper stream when both ports start a frame together.
   wire a_start = a_rx_valid && !a_in;
   wire b_start = b_rx_valid && !b_in && !(a_start && !b_in && parallel);
   reg  a_hit;
   reg  b_hit;
   reg  b_hit_pair;
   always @* begin
      a_hit = 1'b0;
      b_hit = 1'b0;
      b_hit_pair = 1'b0;
      for (i = 0; i < `DUP_ENTRIES; i = i + 1) begin
         if (dup_val[i] && dup_src[i] == a_rx_src && dup_seq[i] == a_rx_seq)
            a_hit = 1'b1;
         if (dup_val[i] && dup_src[i] == b_rx_src && dup_seq[i] == b_rx_seq)
            b_hit = 1'b1;
      end
      b_hit_pair = b_hit || (a_start && a_rx_src == b_rx_src &&
                             a_rx_seq == b_rx_seq);
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dup_wr       <= {`DUP_IDX_W{1'b0}};
         last_seq     <= 16'h0;
         a_in         <= 1'b0;
         b_in         <= 1'b0;
         a_drop       <= 1'b0;
         b_drop       <= 1'b0;
         up_rx_data   <= 8'h00;
         up_rx_valid  <= 1'b0;
         up_rx_last   <= 1'b0;
         dup_dropped  <= 1'b0;
         seq_error    <= 1'b0;
         missing_copy <= 1'b0;
         for (j = 0; j < `DUP_ENTRIES; j = j + 1) begin
            dup_src[j] <= 48'h0;
            dup_seq[j] <= 16'h0;
            dup_val[j] <= 1'b0;
         end
      end else begin
         up_rx_valid  <= 1'b0;
         up_rx_last   <= 1'b0;
         dup_dropped  <= 1'b0;
         seq_error    <= 1'b0;
         missing_copy <= 1'b0;
         if (a_start) begin
            a_in   <= !a_rx_last;
            a_drop <= stp_hold || (parallel && a_hit) ||
                      (mode == `MODE_FAILOVER && active_b);
            if (parallel && a_hit)
               dup_dropped <= 1'b1;
            if (parallel && !a_hit) begin
               dup_src[dup_wr] <= a_rx_src;
               dup_seq[dup_wr] <= a_rx_seq;
               dup_val[dup_wr] <= 1'b1;
               dup_wr          <= dup_wr + 1'b1;
               if (dup_val[dup_wr])
                  missing_copy <= 1'b1;
               seq_error <= (a_rx_seq != last_seq + 16'h1);
               last_seq  <= a_rx_seq;
            end
         end else if (a_rx_valid && a_rx_last)
            a_in <= 1'b0;
         if (b_start) begin
            b_in   <= !b_rx_last;
            b_drop <= stp_hold || (parallel && b_hit_pair) ||
                      (mode == `MODE_FAILOVER && !active_b) ||
                      (mode == `MODE_RSTP);
            if (parallel && b_hit_pair)
               dup_dropped <= 1'b1;
            if (parallel && !b_hit_pair && !a_start) begin
               dup_src[dup_wr] <= b_rx_src;
               dup_seq[dup_wr] <= b_rx_seq;
               dup_val[dup_wr] <= 1'b1;
               dup_wr          <= dup_wr + 1'b1;
               if (dup_val[dup_wr])
                  missing_copy <= 1'b1;
               seq_error <= (b_rx_seq != last_seq + 16'h1);
               last_seq  <= b_rx_seq;
            end
         end else if (b_rx_valid && b_rx_last)
            b_in <= 1'b0;
         // A matched entry is retired so an unmatched one flags loss.
         for (j = 0; j < `DUP_ENTRIES; j = j + 1) begin
            if (parallel && a_start && a_hit && dup_src[j] == a_rx_src &&
                dup_seq[j] == a_rx_seq)
               dup_val[j] <= 1'b0;
            if (parallel && b_start && b_hit && dup_src[j] == b_rx_src &&
                dup_seq[j] == b_rx_seq)
               dup_val[j] <= 1'b0;
         end
         // One upper stream hides both networks.
         if (a_rx_valid && !(a_start ? (stp_hold || (parallel && a_hit) ||
             (mode == `MODE_FAILOVER && active_b)) : a_drop)) begin
            up_rx_data  <= a_rx_data;
            up_rx_valid <= 1'b1;
            up_rx_last  <= a_rx_last;
         end else if (b_rx_valid && !(b_start ? (stp_hold ||
                      (parallel && b_hit_pair) ||
                      (mode == `MODE_FAILOVER && !active_b) ||
                      (mode == `MODE_RSTP)) : b_drop)) begin
            up_rx_data  <= b_rx_data;
            up_rx_valid <= 1'b1;
            up_rx_last  <= b_rx_last;
         end
      end
   end
endmodule

/* File: src/redundant_port_map.vh */
// Constants for the redundant station bus port logic.
// Assumes inclusion by bare name from the design files under src/.
`ifndef REDUNDANT_PORT_MAP_VH
`define REDUNDANT_PORT_MAP_VH

// ****************************************************************
// Modes
// ****************************************************************
`define MODE_FAILOVER        2'h0
`define MODE_RSTP            2'h1
`define MODE_PRP             2'h2
`define MODE_HSR             2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS        10
`define CYCLES_PER_MS        100000
`define FAILOVER_MIN_MS      16'h07d0
`define LIFE_CHECK_DEF_MS    2000
`define FAILOVER_DEF_MS      2000

// ****************************************************************
// Spanning tree settings, times in seconds
// ****************************************************************
`define MAX_AGE_DEF          6'h14
`define MAX_AGE_MIN          6'h06
`define MAX_AGE_MAX          6'h28
`define HELLO_DEF            6'h02
`define HELLO_MIN            6'h01
`define HELLO_MAX            6'h0a
`define FWD_DELAY_DEF        6'h0f
`define FWD_DELAY_MIN        6'h04
`define FWD_DELAY_MAX        6'h1e
`define PRIORITY_DEF         16'h8000
`define PRIORITY_MAX         16'hf000

// ****************************************************************
// Duplicate table and supervision frame
// ****************************************************************
`define DUP_ENTRIES          8
`define DUP_IDX_W            3
`define SUP_LEN              5'h12

`endif

/* File: src/ms_tick.v */
// Millisecond enable divider for the redundant port logic.
// Assumes one 100 MHz clock and an asynchronous active-low reset.
`timescale 1ns/10ps
`include "redundant_port_map.vh"

module ms_tick #(
   parameter CYCLES = `CYCLES_PER_MS
) (
   input  wire core_clk,
   input  wire rst_n,
   output reg  tick
);
   reg [31:0] count;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 32'h0;
         tick  <= 1'b0;
      end else if (count == CYCLES - 1) begin
         count <= 32'h0;
         tick  <= 1'b1;
      end else begin
         count <= count + 32'h1;
         tick  <= 1'b0;
      end
   end
endmodule

/* File: verification/redundant_port_checker.sv */
// Port-level assertions for the redundant port logic.
// Assumes a bind onto redundant_port with a single clock domain.
`timescale 1ns/10ps
module redundant_port_checker (
   input wire        core_clk,
   input wire        rst_n,
   input wire [1:0]  mode,
   input wire        main_port_b,
   input wire        topology_recalc,
   input wire        link_a,
   input wire        link_b,
   input wire [7:0]  up_tx_data,
   input wire        up_tx_valid,
   input wire        up_tx_ready,
   input wire        up_rx_valid,
   input wire [7:0]  a_tx_data,
   input wire        a_tx_valid,
   input wire [7:0]  b_tx_data,
   input wire        b_tx_valid,
   input wire        a_rx_valid,
   input wire        b_rx_valid,
   input wire        active_b,
   input wire        dup_dropped,
   input wire [5:0]  max_age,
   input wire [5:0]  hello_time,
   input wire [5:0]  fwd_delay,
   input wire [15:0] bridge_priority
);
   // ****
   // Properties
   // ****
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   wire dual = mode[1];
   wire hold = mode == 2'h1 && topology_recalc;
   a_dual_send: assert property (
      up_tx_valid && up_tx_ready && dual ##1 dual |->
      a_tx_valid && b_tx_valid && a_tx_data == $past(up_tx_data))
      else $error("byte not on both ports");
   a_ports_match: assert property (
      dual && $stable(mode) && a_tx_valid |->
      b_tx_valid && b_tx_data == a_tx_data)
      else $error("ports differ");
   a_one_port: assert property (
      mode == 2'h0 && $stable(mode) |-> !(a_tx_valid && b_tx_valid))
      else $error("both ports active");
   a_recalc_tx: assert property (hold |-> !up_tx_ready)
      else $error("tx taken in recalc");
   a_recalc_rx: assert property (hold [*2] |-> !up_rx_valid)
      else $error("rx passed in recalc");
   a_stp_range: assert property (
      max_age inside {[6'h06:6'h28]} && hello_time inside {[6'h01:6'h0a]}
      && fwd_delay inside {[6'h04:6'h1e]})
      else $error("setting out of range");
   a_prio_step: assert property (
      bridge_priority[11:0] == 12'h000 && bridge_priority <= 16'hf000)
      else $error("bad priority");
   a_main_port: assert property (
      (mode == 2'h0 && link_a && link_b && $stable(main_port_b)) [*6]
      |-> active_b == main_port_b)
      else $error("main port not active");
   a_rx_cause: assert property (
      up_rx_valid |-> $past(a_rx_valid || b_rx_valid))
      else $error("rx byte from nowhere");
   a_dup_cause: assert property (
      dup_dropped |-> $past(a_rx_valid || b_rx_valid))
      else $error("drop without input");
   c_dup: cover property (dup_dropped);
   c_switch: cover property (mode == 2'h0 && active_b);
   c_dual: cover property (dual && a_tx_valid);
endmodule

bind redundant_port redundant_port_checker chk (.*);

/* File: verification/lan_pair_model.sv */
// Two parallel LANs feeding the receive side of the redundant port.
// Assumes the bench calls frame; lines change 1 ns after a rising edge.
`timescale 1ns/10ps
module lan_pair_model (
   input  wire        core_clk,
   output reg  [7:0]  a_rx_data,
   output reg         a_rx_valid,
   output reg         a_rx_last,
   output reg  [47:0] a_rx_src,
   output reg  [15:0] a_rx_seq,
   output reg  [7:0]  b_rx_data,
   output reg         b_rx_valid,
   output reg         b_rx_last,
   output reg  [47:0] b_rx_src,
   output reg  [15:0] b_rx_seq
);
   initial begin
      {a_rx_data, a_rx_valid, a_rx_last, a_rx_src, a_rx_seq} = 0;
      {b_rx_data, b_rx_valid, b_rx_last, b_rx_src, b_rx_seq} = 0;
   end
   task put(input bit p, input [7:0] d, input bit v, l,
            input [47:0] s, input [15:0] q);
      if (p) {b_rx_data, b_rx_valid, b_rx_last, b_rx_src, b_rx_seq} =
         {d, v, l, s, q};
      else {a_rx_data, a_rx_valid, a_rx_last, a_rx_src, a_rx_seq} =
         {d, v, l, s, q};
   endtask
   // Idle lines show inverted values so stale bytes are never reused.
   task frame(input bit b_first, both, input [47:0] s, input [15:0] q,
              input int len);
      for (int k = 0; k < 2; k++) begin
         if (k == 0 || both) begin
            for (int i = 0; i < len; i++) begin
               @(posedge core_clk);
               #1 put(b_first ^ k[0], q[7:0] + i[7:0], 1'b1,
                      i == len - 1, s, q);
            end
            @(posedge core_clk);
            #1 put(b_first ^ k[0], ~(q[7:0] + len[7:0] - 8'h01), 1'b0,
                   1'b0, ~s, ~q);
            repeat (3) @(posedge core_clk);
         end
      end
      #1;
   endtask
endmodule

/* File: verification/redundant_port_bench.sv */
// Self-checking bench for the redundant port logic.
// Assumes lan_pair_model on the receive side and a 10-cycle ms tick.
`timescale 1ns/10ps
module redundant_port_bench;
   reg         core_clk = 1'b0;
   reg         rst_n = 1'b0;
   reg  [1:0]  mode = 2'h1;
   reg         main_port_b = 1'b0;
   reg         topology_recalc = 1'b0;
   reg         link_a = 1'b1;
   reg         link_b = 1'b1;
   reg  [15:0] failover_ms = 16'h0005;
   reg  [15:0] life_check_ms = 16'hffff;
   reg  [47:0] sup_dest_addr = 48'h0123456789ab;
   reg  [5:0]  max_age_set = 6'h14;
   reg  [5:0]  hello_set = 6'h02;
   reg  [5:0]  fwd_delay_set = 6'h0f;
   reg  [15:0] priority_set = 16'h8000;
   reg  [7:0]  up_tx_data = 8'h00;
   reg         up_tx_valid = 1'b0;
   reg         up_tx_last = 1'b0;
   wire [7:0]  up_rx_data, a_tx_data, b_tx_data, a_rx_data, b_rx_data;
   wire [47:0] a_rx_src, b_rx_src;
   wire [15:0] a_rx_seq, b_rx_seq, bridge_priority;
   wire [5:0]  max_age, hello_time, fwd_delay;
   wire        up_tx_ready, up_rx_valid, up_rx_last, a_tx_valid, a_tx_last;
   wire        b_tx_valid, b_tx_last, a_rx_valid, a_rx_last, b_rx_valid;
   wire        b_rx_last, active_b, dup_dropped, seq_error, missing_copy;
   logic [7:0] qa[$], qb[$], qu[$], e;
   int         t_sup[$];
   int         n_dup = 0, n_seq = 0, cyc = 0, n_fail = 0, n_checks = 0;
   int         n_miss = 0;
   reg         prev_a = 1'b0;

   redundant_port #(.CYCLES_MS(10)) dut (.*);
   lan_pair_model lan (.*);

   // ****
   // Clock, timeout and monitor
   // ****
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         end_sim;
      end
   end
   // Outputs are sampled mid-cycle, clear of the launching edge.
   always @(negedge core_clk) begin
      if (a_tx_valid === 1'b1) qa.push_back(a_tx_data);
      if (a_tx_valid === 1'b1 && !prev_a) t_sup.push_back(cyc);
      prev_a = a_tx_valid === 1'b1;
      if (b_tx_valid === 1'b1) qb.push_back(b_tx_data);
      if (up_rx_valid === 1'b1) qu.push_back(up_rx_data);
      n_dup += dup_dropped === 1'b1;
      n_seq += seq_error === 1'b1;
      n_miss += missing_copy === 1'b1;
   end

   // ****
   // Tasks
   // ****
   task chk(input logic [47:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task clr;
      qa.delete();
      qb.delete();
      qu.delete();
   endtask
   task tx(input int len);
      for (int i = 0; i < len; i++) begin
         up_tx_data = 8'h30 + i[7:0];
         {up_tx_valid, up_tx_last} = {1'b1, i == len - 1};
         while (up_tx_ready !== 1'b1) @(negedge core_clk);
         step(1);
      end
      {up_tx_valid, up_tx_last} = 2'b00;
   endtask
   task chk_q(input logic [7:0] q[$], input logic [7:0] base, input int n);
      chk(q.size(), n);
      foreach (q[i]) chk(q[i], base + i[7:0]);
   endtask

   // ****
   // Tests
   // ****
   initial begin
      step(5);
      chk({max_age, hello_time, fwd_delay}, {6'h14, 6'h02, 6'h0f});
      chk({bridge_priority, up_tx_ready, active_b}, 18'h20002);
      rst_n = 1'b1;
      step(4);
      for (int r = 0; r < 2; r++) begin
         {max_age_set, hello_set, fwd_delay_set} =
            r ? {6'h32, 6'h30, 6'h3f} : {6'h02, 6'h00, 6'h03};
         priority_set = r ? 16'hffff : 16'h1234;
         step(3);
         chk({max_age, hello_time, fwd_delay},
             r ? {6'h28, 6'h0a, 6'h1e} : {6'h06, 6'h01, 6'h04});
         chk(bridge_priority, r ? 16'hf000 : 16'h1000);
      end
      topology_recalc = 1'b1;
      step(1);
      chk(up_tx_ready, 1'b0);
      clr;
      lan.frame(1'b0, 1'b0, 48'h1, 16'h0009, 4);
      chk(qu.size(), 0);
      topology_recalc = 1'b0;
      step(1);
      tx(3);
      step(3);
      chk_q(qa, 8'h30, 3);
      chk(qb.size(), 0);
      $display("rstp done");
      for (int m = 2; m < 4; m++) begin
         mode = m[1:0];
         clr;
         step(2);
         tx(4);
         step(3);
         chk_q(qa, 8'h30, 4);
         chk_q(qb, 8'h30, 4);
      end
      $display("dual tx done");
      mode = 2'h2;
      clr;
      lan.frame(1'b0, 1'b1, 48'h1, 16'h0010, 5);
      chk_q(qu, 8'h10, 5);
      chk(n_dup != 0, 1'b1);
      {n_dup, n_seq} = 64'h0;
      clr;
      lan.frame(1'b1, 1'b1, 48'h1, 16'h0011, 5);
      chk_q(qu, 8'h11, 5);
      chk(n_dup != 0, 1'b1);
      lan.frame(1'b0, 1'b1, 48'h1, 16'h0013, 2);
      chk(n_seq, 1);
      clr;
      lan.frame(1'b0, 1'b0, 48'h2, 16'h0011, 3);
      chk_q(qu, 8'h11, 3);
      // Eight single copies wrap the table onto the one unmatched entry.
      for (int f = 0; f < 8; f++)
         lan.frame(1'b0, 1'b0, 48'h3, f[15:0], 1);
      chk(n_miss, 1);
      $display("prp rx done");
      life_check_ms = 16'h0003;
      clr;
      t_sup.delete();
      step(90);
      chk(t_sup[1] - t_sup[0], 30);
      for (int i = 0; i < 18; i++) begin
         e = i < 6 ? sup_dest_addr[47 - 8 * i -: 8] : 8'h88;
         chk({qa[i], qb[i]}, {e, e});
      end
      life_check_ms = 16'hffff;
      step(40);
      $display("supervision done");
      main_port_b = 1'b1;
      mode = 2'h0;
      step(8);
      chk(active_b, 1'b1);
      clr;
      tx(2);
      step(3);
      chk(qa.size(), 0);
      chk_q(qb, 8'h30, 2);
      main_port_b = 1'b0;
      step(8);
      chk(active_b, 1'b0);
      link_a = 1'b0;
      step(19980);
      chk(active_b, 1'b0);
      step(50);
      chk(active_b, 1'b1);
      link_a = 1'b1;
      step(8);
      chk(active_b, 1'b0);
      $display("failover done");
      end_sim;
   end
endmodule
